// >>> ossc_top.sv
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module ossc_top
  import ossc_pkg::*;
#(
  parameter int ALT_HALF_CYCLES = ALT_CYCLES
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  // AXI4-Lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Control output levels, counter storage check and screen type
  input  wire logic [1:0]        ctrl_out,
  input  wire logic [1:0]        data_err,
  input  wire logic              screen_is_pv,
  // Alarm and display
  output logic [1:0]             count_alarm,
  output logic                   alarm_ctrl_out,
  output logic                   alarm_aux_out,
  output logic                   pv_shown,
  output logic                   count_alarm_banner,
  output logic                   monitor_visible
);

  // Refuse a half period that the phase counter cannot hold
  if ((ALT_HALF_CYCLES < 2) ||
      (ALT_HALF_CYCLES >= (1 << ALT_W))) begin : g_bad_alt
    $error("ALT_HALF_CYCLES out of range");
  end

  // Last count of one display half period
  localparam logic [ALT_W-1:0] ALT_LAST =
    ALT_W'(ALT_HALF_CYCLES - 1);

  // Every register of the block except the counters in ossc_chan, bus side included
  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [CTRL_W-1:0] ctrl;
    logic [MON_W-1:0]  th1;
    logic [MON_W-1:0]  th2;
    logic [1:0]        rst_sel;
    logic [ALT_W-1:0]  alt_cnt;
    logic              phase;
    logic              alarm_ctrl;
    logic              alarm_aux;
    logic              pv_shown;
    logic              banner;
    logic              visible;
  } ossc_regs_t;

  // Current and next state, then per-output views
  ossc_regs_t          s_q;
  ossc_regs_t          s_d;
  logic [MON_W-1:0]    mon   [2];
  logic [1:0]          alarm;
  logic [1:0]          err;
  logic [1:0]          mode;
  logic [1:0]          clr;
  logic [MON_W-1:0]    th    [2];

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] ossc_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : ossc_merge

  // Threshold writes above the range are held at the top value
  // rather than cut to 14 bits, which could leave zero and stop counting
  function automatic logic [MON_W-1:0] ossc_clamp(input logic [31:0] v);
    if (v > {18'h00000, MON_MAX}) begin
      return MON_MAX;
    end
    return v[MON_W-1:0];
  endfunction : ossc_clamp

  // Per-output configuration and one-cycle reset strobes
  // A selector write clears its output's counter for a single cycle
  assign mode = {s_q.ctrl[CTRL_ONOFF2], s_q.ctrl[CTRL_ONOFF1]};
  assign th[0] = s_q.th1;
  assign th[1] = s_q.th2;
  assign clr[0] = (s_q.rst_sel == RSEL_OUT1);
  assign clr[1] = (s_q.rst_sel == RSEL_OUT2);

  // One counter per on/off control output
  generate
    for (genvar i = 0; i < 2; i++) begin : g_chan
      ossc_chan u_chan (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .onoff_mode (mode[i]),
        .threshold  (th[i]),
        .out_level  (ctrl_out[i]),
        .clr        (clr[i]),
        .data_err   (data_err[i]),
        .monitor    (mon[i]),
        .alarm      (alarm[i]),
        .err        (err[i])
      );
    end
  endgenerate

  // Bus slave, register file and display sequencing
  always_comb begin
    logic [31:0] wv;
    wv  = '0;
    s_d = s_q;
    // Reset selection lasts one cycle, then reads back as zero
    s_d.rst_sel = RSEL_NONE;

    // Address and data are taken separately, in either order
    if (s_q.awready && awvalid) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (s_q.wready && wvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    // Response leaves once the master has seen it
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end

    // Write once both address and data are held
    if (s_d.aw_got && s_d.w_got && !s_d.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      unique case (s_d.awaddr)
        OFF_CTRL: begin
          wv = ossc_merge({27'h0000000, s_q.ctrl}, s_d.wdata, s_d.wstrb);
          s_d.ctrl = wv[CTRL_W-1:0];
        end
        OFF_TH1: begin
          wv = ossc_merge({18'h00000, s_q.th1}, s_d.wdata, s_d.wstrb);
          s_d.th1 = ossc_clamp(wv);
        end
        OFF_TH2: begin
          wv = ossc_merge({18'h00000, s_q.th2}, s_d.wdata, s_d.wstrb);
          s_d.th2 = ossc_clamp(wv);
        end
        OFF_RST_SEL: begin
          wv = ossc_merge(32'h00000000, s_d.wdata, s_d.wstrb);
          // Codes above 2 are ignored
          if (wv <= {30'h00000000, RSEL_OUT2}) begin
            s_d.rst_sel = wv[1:0];
          end
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Ready again only once the response is gone: one write in
    // flight, so no queue is needed behind the register file
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready  = !s_d.w_got && !s_d.bvalid;

    // Read channel, one outstanding
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      // Unmapped offsets read as zero with an error response
      unique case (araddr)
        OFF_CTRL:    s_d.rdata = {27'h0000000, s_q.ctrl};
        OFF_TH1:     s_d.rdata = {18'h00000, s_q.th1};
        OFF_TH2:     s_d.rdata = {18'h00000, s_q.th2};
        OFF_RST_SEL: s_d.rdata = {30'h00000000, s_q.rst_sel};
        OFF_MON1:    s_d.rdata = {18'h00000, mon[0]};
        OFF_MON2:    s_d.rdata = {18'h00000, mon[1]};
        OFF_STATUS:  s_d.rdata = {26'h0000000, s_q.banner, s_q.visible,
                                  err, alarm};
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Next read accepted once the data has been taken
    s_d.arready = !s_d.rvalid;

    // Routing of the combined count alarm
    s_d.alarm_ctrl = s_q.ctrl[CTRL_RT_CTRL] && (|alarm);
    s_d.alarm_aux  = s_q.ctrl[CTRL_RT_AUX] && (|alarm);

    // Monitors hidden when both thresholds are zero or both linear;
    // no output counts while hidden, as counting needs on/off mode and a nonzero threshold
    s_d.visible = ((s_q.th1 != MON_ZERO) || (s_q.th2 != MON_ZERO)) &&
                  (|mode);

    // Half-second phase; free running so both displays stay in step
    if (s_q.alt_cnt == ALT_LAST) begin
      s_d.alt_cnt = '0;
      s_d.phase   = !s_q.phase;
    end else begin
      s_d.alt_cnt = s_q.alt_cnt + ALT_W'(1);
    end

    // Alternate only on process-value screens with display enabled
    if ((|alarm) && screen_is_pv && s_q.ctrl[CTRL_DISP_EN]) begin
      s_d.pv_shown = !s_q.phase;
      s_d.banner   = s_q.phase;
    end else begin
      s_d.pv_shown = 1'b1;
      s_d.banner   = 1'b0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q      <= '0;
      // Both outputs leave reset in on/off mode, display enabled
      s_q.ctrl <= CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign awready            = s_q.awready;
  assign wready             = s_q.wready;
  assign bvalid             = s_q.bvalid;
  assign bresp              = s_q.bresp;
  assign arready            = s_q.arready;
  assign rvalid             = s_q.rvalid;
  assign rresp              = s_q.rresp;
  assign rdata              = s_q.rdata;
  assign count_alarm        = alarm;
  assign alarm_ctrl_out     = s_q.alarm_ctrl;
  assign alarm_aux_out      = s_q.alarm_aux;
  assign pv_shown           = s_q.pv_shown;
  assign count_alarm_banner = s_q.banner;
  assign monitor_visible    = s_q.visible;

endmodule : ossc_top

`default_nettype wire

// >>> ossc_chan.sv
`timescale 1ns/100ps
`default_nettype none

package ossc_pkg;
  // Monitor and threshold range, in units of 100 switching operations
  localparam int             MON_W         = 14;
  localparam logic [13:0]    MON_MAX       = 14'h270f;  // 9999
  localparam logic [13:0]    MON_ZERO      = 14'h0000;
  localparam logic [13:0]    MON_ONE       = 14'h0001;
  // Prescaler counts 0..99 then wraps
  localparam logic [6:0]     PRE_LAST      = 7'h63;
  localparam logic [6:0]     PRE_ONE       = 7'h01;
  // Register map, byte addresses
  localparam int             ADDR_W        = 5;
  localparam logic [4:0]     OFF_CTRL      = 5'h00;
  localparam logic [4:0]     OFF_TH1       = 5'h04;
  localparam logic [4:0]     OFF_TH2       = 5'h08;
  localparam logic [4:0]     OFF_RST_SEL   = 5'h0c;
  localparam logic [4:0]     OFF_MON1      = 5'h10;
  localparam logic [4:0]     OFF_MON2      = 5'h14;
  localparam logic [4:0]     OFF_STATUS    = 5'h18;
  // Control register fields
  localparam int             CTRL_W        = 5;
  localparam int             CTRL_ONOFF1   = 0;
  localparam int             CTRL_ONOFF2   = 1;
  localparam int             CTRL_RT_CTRL  = 2;
  localparam int             CTRL_RT_AUX   = 3;
  localparam int             CTRL_DISP_EN  = 4;
  localparam logic [4:0]     CTRL_RST      = 5'h13;
  // Counter reset selector encoding
  localparam logic [1:0]     RSEL_NONE     = 2'h0;
  localparam logic [1:0]     RSEL_OUT1     = 2'h1;
  localparam logic [1:0]     RSEL_OUT2     = 2'h2;
  // Bus responses
  localparam logic [1:0]     RESP_OKAY     = 2'h0;
  localparam logic [1:0]     RESP_SLVERR   = 2'h2;
  // Display alternation: half period of 0.5 s (1 s cycle) at 200 MHz
  localparam longint         CLK_FREQ_HZ   = 200000000;
  localparam longint         ALT_HALF_MS   = 500;
  localparam int             ALT_CYCLES    =
    int'(ALT_HALF_MS * (CLK_FREQ_HZ / 1000));
  localparam int             ALT_W         = 27;
endpackage : ossc_pkg

module ossc_chan
  import ossc_pkg::*;
(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Configuration
  input  wire logic             onoff_mode,
  input  wire logic [MON_W-1:0] threshold,
  // Events
  input  wire logic             out_level,
  input  wire logic             clr,
  input  wire logic             data_err,
  // State
  output logic      [MON_W-1:0] monitor,
  output logic                  alarm,
  output logic                  err
);

  typedef struct packed {
    logic             prev;
    logic [6:0]       pre;
    logic [MON_W-1:0] mon;
    logic             err;
    logic             alarm;
  } ossc_chan_t;

  ossc_chan_t s_q;
  ossc_chan_t s_d;
  logic       active;

  // Next state of one output's counter
  always_comb begin
    s_d    = s_q;
    active = onoff_mode && (threshold != MON_ZERO);
    s_d.prev = out_level;
    if (clr) begin
      s_d.pre = '0;
      s_d.mon = MON_ZERO;
      s_d.err = 1'b0;
    end else if (active && s_q.prev && !out_level) begin
      // One on-to-off cycle counted per falling edge
      if (s_q.pre == PRE_LAST) begin
        s_d.pre = '0;
        if (s_q.mon != MON_MAX) begin
          s_d.mon = s_q.mon + MON_ONE;
        end
      end else begin
        s_d.pre = s_q.pre + PRE_ONE;
      end
    end
    // Corruption beats a same-cycle reset so no error is lost
    if (data_err || (s_q.mon > MON_MAX)) begin
      s_d.err = 1'b1;
      s_d.mon = MON_MAX;
    end
    s_d.alarm = s_d.err ||
                ((threshold != MON_ZERO) && (s_d.mon > threshold));
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign monitor = s_q.mon;
  assign alarm   = s_q.alarm;
  assign err     = s_q.err;

endmodule : ossc_chan

`default_nettype wire

// >>> ossc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ossc_checker
  import ossc_pkg::*;
(
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Bus handshakes
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       rvalid,
  input wire logic       arready,
  // Switching, faults and alarms
  input wire logic [1:0] ctrl_out,
  input wire logic [1:0] data_err,
  input wire logic [1:0] count_alarm,
  input wire logic       alarm_ctrl_out,
  input wire logic       alarm_aux_out,
  input wire logic       pv_shown,
  input wire logic       count_alarm_banner
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] lvl_q;
  logic [7:0] f0_q, f1_q;
  logic [3:0] since_q;
  // Off edges since reset, saturating; never cleared by the selector,
  // so the bound below is loose but cannot fire falsely
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_q   <= 2'h0;
      f0_q    <= 8'h00;
      f1_q    <= 8'h00;
      since_q <= 4'hf;
    end else begin
      lvl_q <= ctrl_out;
      if (lvl_q[0] && !ctrl_out[0] && f0_q != 8'hff) f0_q <= f0_q + 8'h01;
      if (lvl_q[1] && !ctrl_out[1] && f1_q != 8'hff) f1_q <= f1_q + 8'h01;
      if (awvalid && awready) since_q <= 4'h0;
      else if (since_q != 4'hf) since_q <= since_q + 4'h1;
    end
  end
  a_route_ctrl: assert property (alarm_ctrl_out |-> $past(|count_alarm))
    else $error("control output alarm without count alarm");
  a_route_aux: assert property (alarm_aux_out |-> $past(|count_alarm))
    else $error("aux output alarm without count alarm");
  a_banner_cause: assert property ($rose(count_alarm_banner) |->
    $past(|count_alarm)) else $error("banner without alarm");
  a_pv_idle: assert property ((count_alarm == 2'h0)[*3] |-> pv_shown)
    else $error("pv hidden without alarm");
  a_err_alarm0: assert property (data_err[0] |=> count_alarm[0])
    else $error("data error 1 gave no alarm");
  a_err_alarm1: assert property (data_err[1] |=> count_alarm[1])
    else $error("data error 2 gave no alarm");
  a_alarm_cause0: assert property ($rose(count_alarm[0]) |->
    f0_q >= 8'hc8 || $past(data_err[0])) else $error("early alarm 1");
  a_alarm_cause1: assert property ($rose(count_alarm[1]) |->
    f1_q >= 8'hc8 || $past(data_err[1])) else $error("early alarm 2");
  a_clear_write: assert property ($fell(count_alarm[0]) |->
    since_q <= 4'h5) else $error("alarm 1 fell without a write");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  c_alarm: cover property ($rose(count_alarm[0]));
  c_banner: cover property ($rose(count_alarm_banner));
  c_err: cover property (data_err[1] ##1 count_alarm[1]);
endmodule : ossc_checker
bind ossc_top ossc_checker u_chk (.aclk, .aresetn, .awvalid, .awready,
  .rvalid, .arready, .ctrl_out, .data_err, .count_alarm, .alarm_ctrl_out,
  .alarm_aux_out, .pv_shown, .count_alarm_banner);
`default_nettype wire

// >>> ossc_relay.sv
`timescale 1ns/100ps
`default_nettype none
module ossc_relay (
  // Clock
  input  wire logic        aclk,
  // Command: one-hot output and operation count
  input  wire logic [1:0]  go,
  input  wire logic [15:0] n,
  // Drive levels, off while idle
  output logic      [1:0]  ctrl_out,
  output logic             busy
);
  logic [1:0]  sel_q  = 2'h0;
  logic [15:0] left_q = 16'h0000;
  initial ctrl_out = 2'h0;
  // One on cycle, then one off cycle, per operation
  always @(posedge aclk) begin
    if (go != 2'h0) begin
      sel_q  <= go;
      left_q <= n;
    end else if (left_q != 16'h0000) begin
      if ((ctrl_out & sel_q) != 2'h0) begin
        ctrl_out <= 2'h0;
        left_q   <= left_q - 16'h0001;
      end else begin
        ctrl_out <= sel_q;
      end
    end
  end
  assign busy = left_q != 16'h0000;
endmodule : ossc_relay
`default_nettype wire

// >>> ossc_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module ossc_top_test
  import ossc_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b1, rready = 1'b1, screen_is_pv = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  data_err = 2'h0, go = 2'h0, bresp, rresp, wresp;
  logic [1:0]  ctrl_out, count_alarm;
  logic [15:0] n = 16'h0000;
  logic        awready, wready, bvalid, arready, rvalid, busy;
  logic        alarm_ctrl_out, alarm_aux_out, pv_shown;
  logic        count_alarm_banner, monitor_visible;
  int          fail_count = 0, cmp_count = 0;
  // Short alternation keeps the banner phase within reach
  ossc_top #(.ALT_HALF_CYCLES(8)) dut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .ctrl_out, .data_err, .screen_is_pv, .count_alarm, .alarm_ctrl_out,
    .alarm_aux_out, .pv_shown, .count_alarm_banner, .monitor_visible);
  ossc_relay u_relay (.aclk, .go, .n, .ctrl_out, .busy);
  always #2.5 aclk = ~aclk;
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task timed_out;
    fail_count++;
    $display("[FAIL] wait exp done got timeout");
    test_done;
  endtask : timed_out
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  // Ready lines stay high, so only valid and payload move
  task wr(input logic [4:0] a, input logic [31:0] d);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    i = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      i++;
    end while (!bvalid && i < 50);
    wresp = bresp;
    if (i == 50) timed_out;
  endtask : wr
  task rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    i = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      i++;
    end while (!rvalid && i < 50);
    d = rdata;
    r = rresp;
    if (i == 50) timed_out;
  endtask : rd
  task rc(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, e, d);
  endtask : rc
  // Run k on/off operations on one output and wait for the last off
  task sw(input logic [1:0] o, input logic [15:0] k);
    int i;
    go <= o;
    n <= k;
    @(posedge aclk);
    go <= 2'h0;
    i = 0;
    do begin
      @(posedge aclk);
      i++;
    end while (busy && i < 2000);
    if (i == 2000) timed_out;
  endtask : sw
  // Covers the one-cycle alarm, routing and display register delays
  task settle;
    repeat (4) @(posedge aclk);
  endtask : settle
  task t_reset;
    rc("ctrl", OFF_CTRL, 32'h13);
    rc("th1", OFF_TH1, 32'h0);
    rc("rsel", OFF_RST_SEL, 32'h0);
    rc("mon2", OFF_MON2, 32'h0);
    chk("visible", 32'h0, monitor_visible);
    $display("test reset done");
  endtask : t_reset
  task t_count;
    int i;
    sw(2'h1, 16'h00fa);
    rc("mon1", OFF_MON1, 32'h0);
    wr(OFF_TH1, 32'h1);
    wr(OFF_TH2, 32'h5);
    chk("bresp", RESP_OKAY, wresp);
    settle;
    chk("visible", 32'h1, monitor_visible);
    sw(2'h1, 16'h00c7);
    rc("mon1", OFF_MON1, 32'h1);
    chk("alarm", 32'h0, count_alarm);
    sw(2'h1, 16'h0001);
    rc("mon1", OFF_MON1, 32'h2);
    rc("mon2", OFF_MON2, 32'h0);
    chk("alarm", 32'h1, count_alarm);
    chk("alarm_ctrl", 32'h0, alarm_ctrl_out);
    wr(OFF_CTRL, 32'h1f);
    settle;
    chk("alarm_ctrl", 32'h1, alarm_ctrl_out);
    chk("alarm_aux", 32'h1, alarm_aux_out);
    screen_is_pv <= 1'b1;
    for (i = 0; i < 40 && count_alarm_banner !== 1'b1; i++) @(posedge aclk);
    chk("banner", 32'h1, count_alarm_banner);
    chk("pv_shown", 32'h0, pv_shown);
    wr(OFF_RST_SEL, 32'h1);
    settle;
    rc("mon1", OFF_MON1, 32'h0);
    rc("rsel", OFF_RST_SEL, 32'h0);
    chk("alarm", 32'h0, count_alarm);
    screen_is_pv <= 1'b0;
    $display("test count done");
  endtask : t_count
  task t_error;
    data_err <= 2'h2;
    @(posedge aclk);
    data_err <= 2'h0;
    settle;
    chk("alarm", 32'h2, count_alarm);
    rc("mon2", OFF_MON2, 32'h270f);
    rc("status", OFF_STATUS, 32'h1a);
    chk("pv_shown", 32'h1, pv_shown);
    wr(OFF_TH2, 32'hffff);
    rc("th2", OFF_TH2, 32'h270f);
    sw(2'h2, 16'h0064);
    rc("mon2", OFF_MON2, 32'h270f);
    chk("alarm", 32'h2, count_alarm);
    wr(OFF_RST_SEL, 32'h3);
    settle;
    chk("alarm", 32'h2, count_alarm);
    wr(OFF_RST_SEL, 32'h2);
    settle;
    rc("mon2", OFF_MON2, 32'h0);
    chk("alarm", 32'h0, count_alarm);
    $display("test error done");
  endtask : t_error
  task t_linear;
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_CTRL, 32'h10);
    sw(2'h1, 16'h00c8);
    rc("mon1", OFF_MON1, 32'h0);
    settle;
    chk("visible", 32'h0, monitor_visible);
    rd(5'h1c, d, r);
    chk("resp", RESP_SLVERR, r);
    wr(OFF_MON1, 32'h5);
    chk("bresp", RESP_SLVERR, wresp);
    rc("mon1", OFF_MON1, 32'h0);
    $display("test linear done");
  endtask : t_linear
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_count;
    t_error;
    t_linear;
    test_done;
  end
endmodule : ossc_top_test
`default_nettype wire
